/* verilog/tce_pkg.sv */
// shared types and constants for the trace context and target element block
package tce_pkg;

	// ----------------------------------------------------------------
	// element stream encoding
	// ----------------------------------------------------------------
	localparam logic [2:0] KIND_FLOW = 3'h0;
	localparam logic [2:0] KIND_EXCEPTION = 3'h1;
	localparam logic [2:0] KIND_TSTART = 3'h2;
	localparam logic [2:0] KIND_CONTEXT = 3'h3;
	localparam logic [2:0] KIND_TARGET = 3'h4;

	// exception packet type codes (values are arbitrary)
	localparam logic [4:0] EXC_TX_FAIL = 5'h18;
	localparam logic [4:0] EXC_PE_RESET = 5'h00;

	// ----------------------------------------------------------------
	// sizes and reset values
	// ----------------------------------------------------------------
	localparam int FIFO_DEPTH = 8;
	localparam logic [63:0] ADDR_RESET = 64'h0000_0000_0000_0000;
	localparam logic [31:0] CTX_ZERO = 32'h0000_0000;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	// processor events: pulses except in_tx and trace_active
	typedef struct packed {
		logic in_tx;
		logic trace_active;
		logic tx_enter;
		logic tx_exit;
		logic tx_fail;
		logic prohibited_enter;
		logic trace_disable;
		logic buf_overflow;
		logic proc_reset;
		logic ctx_change;
		logic sysreg_ctx_write;
		logic mispec_ctx;
		logic mispec_addr;
		logic q_element;
		logic sync_nonperiodic;
		logic sync_periodic;
	} tce_event_type;

	// static configuration levels
	typedef struct packed {
		logic vctx_trace_en;
		logic hyp_vmid_trace_allow;
		logic high_el_64;
		logic reset_trace_required;
		logic branch_broadcast_control;
	} tce_cfg_type;

	// one flow change from the core
	typedef struct packed {
		logic is_exception;
		logic [4:0] exc_type;
		logic taken;
		logic indirect;
		logic cse;
		logic rs_match;
		logic target_active;
		logic [63:0] target;
	} tce_flow_type;

	// one element of the output stream
	typedef struct packed {
		logic [2:0] kind;
		logic [4:0] exc_type;
		logic [63:0] addr;
		logic [31:0] ctx_id;
		logic [31:0] vmid;
	} tce_elem_type;

	typedef enum logic [2:0] {
		SEL_NONE = 3'h0,
		SEL_FAIL = 3'h1,
		SEL_RESET = 3'h2,
		SEL_TSTART = 3'h3,
		SEL_CTX = 3'h4,
		SEL_ADDR = 3'h5,
		SEL_FLOW = 3'h6
	} tce_sel_type;

endpackage

/* verilog/tce_top.sv */
// element emitter for transaction, context and target elements, with its output fifo
`timescale 1ns/100ps

// ----------------------------------------------------------------
// shift-register fifo: head and valid bits are flip-flops
// ----------------------------------------------------------------
module tce_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [DEPTH-1:0] vld;
	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic [CW-1:0] wr_pos;
	logic push;
	logic pop;

	// full shows as the last slot occupied, so ready is a plain flop bit
	assign in_ready = ~vld[DEPTH-1];
	assign out_valid = vld[0];
	assign out_data = mem[0];
	assign push = in_valid & ~vld[DEPTH-1];
	assign pop = vld[0] & out_ready;
	assign wr_pos = pop ? cnt - CW'(1) : cnt;
	assign next_cnt = cnt + CW'(push) - CW'(pop);

	// occupancy count
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	// each slot shifts toward the head on pop and takes new data at the tail
	for (genvar i = 0; i < DEPTH; i++) begin : g_slot
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				vld[i] <= 1'b0;
				mem[i] <= '0;
			end else begin
				vld[i] <= (CW'(i) < next_cnt);
				if (push && wr_pos == CW'(i)) begin
					mem[i] <= in_data;
				end else if (pop && i < DEPTH - 1) begin
					mem[i] <= mem[(i < DEPTH - 1) ? i + 1 : i];
				end
			end
		end
	end

	// a stalled head keeps its data
	a_fifo_hold: assert property (@(posedge clk) disable iff (sys_rst)
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("fifo head changed while stalled");
endmodule

// ----------------------------------------------------------------
// emitter
// ----------------------------------------------------------------
module tce_top (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// processor side
	input wire tce_pkg::tce_event_type ev,
	input wire tce_pkg::tce_cfg_type cfg,
	input wire logic [63:0] cur_pc,
	input wire logic [31:0] el1_context_id_register,
	input wire logic [31:0] el2_context_id,
	input wire logic [31:0] vmid_value,
	// flow changes to be traced
	input wire logic fc_valid,
	output logic fc_ready,
	input wire tce_pkg::tce_flow_type fc_data,
	// element stream
	output logic out_valid,
	input wire logic out_ready,
	output tce_pkg::tce_elem_type out_data
);
	tce_pkg::tce_flow_type hold;
	tce_pkg::tce_elem_type push_data;
	tce_pkg::tce_sel_type sel;
	logic hold_valid;
	logic next_hold_valid;
	logic fifo_ready;
	logic tx_start_sent;
	logic tstart_pend;
	logic fail_pend;
	logic reset_pend;
	logic ctx_pend;
	logic ctx_nofc;
	logic ctx_valid;
	logic addr_pend;
	logic [63:0] addr_val;
	logic [63:0] last_target;
	logic tx_kill;
	logic flow_go;
	logic flow_bypass;
	logic flow_need_addr;

	// kill events that end a started transaction with a failure
	assign tx_kill = ev.tx_fail |
		(ev.in_tx & (ev.prohibited_enter | ev.trace_disable | ev.buf_overflow));

	// an exception with no flow since the context write may pass the context
	assign flow_bypass = hold.is_exception & ctx_nofc & ~addr_pend;
	assign flow_go = (sel == tce_pkg::SEL_FLOW);
	assign flow_need_addr = hold.taken & (hold.indirect | hold.is_exception |
		cfg.branch_broadcast_control) & ~hold.rs_match & hold.target_active;

	// ----------------------------------------------------------------
	// arbitration: failure, reset, start, bypassing exception, context, address, then flow
	// ----------------------------------------------------------------
	// one element per cycle keeps the stream order exactly as chosen here
	always_comb begin
		sel = tce_pkg::SEL_NONE;
		if (fifo_ready) begin
			if (fail_pend) begin
				sel = tce_pkg::SEL_FAIL;
			end else if (reset_pend) begin
				sel = tce_pkg::SEL_RESET;
			end else if (tstart_pend) begin
				sel = tce_pkg::SEL_TSTART;
			end else if (hold_valid && flow_bypass) begin
				sel = tce_pkg::SEL_FLOW;
			end else if (ctx_pend) begin
				sel = tce_pkg::SEL_CTX;
			end else if (addr_pend) begin
				sel = tce_pkg::SEL_ADDR;
			end else if (hold_valid) begin
				sel = tce_pkg::SEL_FLOW;
			end
		end
	end

	// element contents for the selected source
	always_comb begin
		push_data = '0;
		push_data.addr = addr_val;
		unique case (sel)
			tce_pkg::SEL_FAIL: begin
				push_data.kind = tce_pkg::KIND_EXCEPTION;
				push_data.exc_type = tce_pkg::EXC_TX_FAIL;
			end
			tce_pkg::SEL_RESET: begin
				push_data.kind = tce_pkg::KIND_EXCEPTION;
				push_data.exc_type = tce_pkg::EXC_PE_RESET;
			end
			tce_pkg::SEL_TSTART: begin
				push_data.kind = tce_pkg::KIND_TSTART;
			end
			tce_pkg::SEL_CTX: begin
				push_data.kind = tce_pkg::KIND_CONTEXT;
				if (!ctx_valid) begin
					push_data.ctx_id = tce_pkg::CTX_ZERO;
				end else if (cfg.high_el_64) begin
					push_data.ctx_id = el1_context_id_register;
				end else begin
					push_data.ctx_id = el2_context_id;
				end
				if (!ctx_valid || (cfg.vctx_trace_en && !cfg.hyp_vmid_trace_allow)) begin
					push_data.vmid = tce_pkg::CTX_ZERO;
				end else begin
					push_data.vmid = vmid_value;
				end
			end
			tce_pkg::SEL_ADDR: begin
				push_data.kind = tce_pkg::KIND_TARGET;
			end
			tce_pkg::SEL_FLOW: begin
				push_data.kind = hold.is_exception ? tce_pkg::KIND_EXCEPTION
					: tce_pkg::KIND_FLOW;
				push_data.exc_type = hold.exc_type;
				push_data.addr = hold.target;
			end
			default: begin
				push_data.kind = tce_pkg::KIND_FLOW;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// transaction tracking
	// ----------------------------------------------------------------
	// start flag lives for one outer transaction; failure requires it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_start_sent <= 1'b0;
			tstart_pend <= 1'b0;
		end else begin
			if (sel == tce_pkg::SEL_TSTART) begin
				tx_start_sent <= 1'b1;
			end else if (sel == tce_pkg::SEL_FAIL || ev.tx_exit || ev.proc_reset) begin
				tx_start_sent <= 1'b0;
			end
			tstart_pend <= (tstart_pend & (sel != tce_pkg::SEL_TSTART)) |
				(ev.tx_enter & ev.trace_active & ~tx_start_sent);
		end
	end

	// failure and reset pending; a new event wins over the emission clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fail_pend <= 1'b0;
			reset_pend <= 1'b0;
		end else begin
			fail_pend <= (fail_pend & (sel != tce_pkg::SEL_FAIL)) |
				(tx_start_sent & (tx_kill |
				(ev.proc_reset & ev.in_tx & cfg.reset_trace_required)));
			// without reset tracing a lone reset packet implies the failure
			reset_pend <= (reset_pend & (sel != tce_pkg::SEL_RESET)) |
				(ev.proc_reset & (cfg.reset_trace_required |
				(tx_start_sent & ev.in_tx)));
		end
	end

	// ----------------------------------------------------------------
	// context tracking
	// ----------------------------------------------------------------
	// ids stay zero after reset until a context register is written
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctx_valid <= 1'b0;
		end else if (ev.proc_reset) begin
			ctx_valid <= 1'b0;
		end else if (ev.ctx_change || ev.sysreg_ctx_write) begin
			ctx_valid <= 1'b1;
		end
	end

	// pending context; real changes, syncs, corrections and an exception with cse set after a context write raise it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctx_pend <= 1'b0;
			ctx_nofc <= 1'b0;
		end else begin
			if (ev.trace_active && (ev.ctx_change || ev.sysreg_ctx_write || ev.mispec_ctx ||
				ev.sync_nonperiodic || ev.sync_periodic)) begin
				ctx_pend <= 1'b1;
			end else if (flow_go && hold.is_exception && hold.cse && ctx_nofc) begin
				ctx_pend <= 1'b1;
			end else if (!ev.trace_active || sel == tce_pkg::SEL_CTX) begin
				ctx_pend <= 1'b0;
			end
			if (ev.sysreg_ctx_write) begin
				ctx_nofc <= 1'b1;
			end else if (flow_go) begin
				ctx_nofc <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// target address tracking
	// ----------------------------------------------------------------
	// later assignments win: a non-periodic sync request overrides a flow-made request
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			addr_pend <= 1'b0;
			addr_val <= tce_pkg::ADDR_RESET;
			last_target <= tce_pkg::ADDR_RESET;
		end else begin
			if (sel == tce_pkg::SEL_ADDR) begin
				addr_pend <= 1'b0;
			end
			if (flow_go) begin
				last_target <= hold.target;
				if (flow_need_addr) begin
					addr_pend <= 1'b1;
					addr_val <= hold.target;
				end
			end
			if (sel == tce_pkg::SEL_FAIL && ev.trace_active) begin
				addr_pend <= 1'b1;
				addr_val <= cur_pc;
			end
			if (ev.q_element || ev.mispec_addr) begin
				addr_pend <= 1'b1;
				addr_val <= cur_pc;
			end
			if (ev.sync_nonperiodic) begin
				addr_pend <= 1'b1;
				addr_val <= cur_pc;
			end else if (ev.sync_periodic && !flow_go) begin
				addr_pend <= 1'b1;
				addr_val <= last_target;
			end
		end
	end

	// ----------------------------------------------------------------
	// flow-change holding slot
	// ----------------------------------------------------------------
	// ready is registered from the next slot state, so it never lags a take
	assign next_hold_valid = (hold_valid & ~flow_go) | (fc_valid & fc_ready);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hold_valid <= 1'b0;
			hold <= '0;
			fc_ready <= 1'b0;
		end else begin
			hold_valid <= next_hold_valid;
			fc_ready <= ~next_hold_valid;
			if (fc_valid && fc_ready) begin
				hold <= fc_data;
			end
		end
	end

	// output buffer; a stalled analyzer stalls the arbiter through fifo_ready
	tce_fifo #(
		.WIDTH($bits(tce_pkg::tce_elem_type)),
		.DEPTH(tce_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(sel != tce_pkg::SEL_NONE),
		.in_ready(fifo_ready),
		.in_data(push_data),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(out_data)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_fail_gated: assert property (@(posedge clk) disable iff (sys_rst)
		!fail_pend && !tx_start_sent |=> !fail_pend)
		else $error("failure element without start element");
	a_fail_raised: assert property (@(posedge clk) disable iff (sys_rst)
		tx_kill && tx_start_sent |=> fail_pend)
		else $error("failure not raised after kill event");
	a_fail_type: assert property (@(posedge clk) disable iff (sys_rst)
		sel == tce_pkg::SEL_FAIL |-> push_data.kind == tce_pkg::KIND_EXCEPTION &&
		push_data.exc_type == tce_pkg::EXC_TX_FAIL)
		else $error("failure element has wrong encoding");
	a_reset_order: assert property (@(posedge clk) disable iff (sys_rst)
		sel == tce_pkg::SEL_RESET |-> !fail_pend)
		else $error("reset packet ahead of failure packet");
	a_ctx_first: assert property (@(posedge clk) disable iff (sys_rst)
		flow_go && !hold.is_exception |-> !ctx_pend && !addr_pend)
		else $error("flow change passed pending context or address");
	a_vmid_zero: assert property (@(posedge clk) disable iff (sys_rst)
		sel == tce_pkg::SEL_CTX && cfg.vctx_trace_en && !cfg.hyp_vmid_trace_allow
		|-> push_data.vmid == tce_pkg::CTX_ZERO)
		else $error("virtual context id not zeroed");
	a_reset_ctx: assert property (@(posedge clk) disable iff (sys_rst)
		ev.proc_reset |=> !ctx_valid)
		else $error("context not cleared by processor reset");
	a_periodic_addr: assert property (@(posedge clk) disable iff (sys_rst)
		ev.sync_periodic && !ev.sync_nonperiodic && !flow_go
		|=> addr_pend && addr_val == $past(last_target))
		else $error("periodic sync address is not last target");
	a_tstart_sent: assert property (@(posedge clk) disable iff (sys_rst)
		sel == tce_pkg::SEL_TSTART |=> tx_start_sent && !tstart_pend)
		else $error("start element not recorded");
endmodule

/* sim/tce_sink.sv */
// trace analyzer stand-in: drains the element stream and logs what it saw
`timescale 1ns/100ps

module tce_sink (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// element stream
	input wire logic out_valid,
	output logic out_ready,
	input wire tce_pkg::tce_elem_type out_data,
	// bench control
	input wire logic stall
);
	tce_pkg::tce_elem_type got[$];

	// ready moves only at the falling edge, so the emitter samples it clean
	initial begin
		out_ready = 1'b0;
		forever begin
			@(negedge clk);
			out_ready = !stall && !sys_rst;
		end
	end

	// popped elements are kept in arrival order; order is what gets judged
	always @(posedge clk) begin
		if (!sys_rst && out_valid && out_ready) begin
			got.push_back(out_data);
		end
	end
endmodule

/* sim/tce_top_tb.sv */
// self-checking bench for the trace element emitter
`timescale 1ns/100ps

module tce_top_tb;
	logic clk;
	logic sys_rst;
	tce_pkg::tce_event_type ev;
	tce_pkg::tce_cfg_type cfg;
	logic [63:0] cur_pc;
	logic [31:0] el1_ctx;
	logic [31:0] el2_ctx;
	logic [31:0] vmid_value;
	logic fc_valid;
	logic fc_ready;
	tce_pkg::tce_flow_type fc_data;
	logic out_valid;
	logic out_ready;
	tce_pkg::tce_elem_type out_data;
	logic stall;
	int error_cnt;
	int samples_checked;
	tce_pkg::tce_elem_type e;

	tce_top dut (.clk(clk), .sys_rst(sys_rst), .ev(ev), .cfg(cfg), .cur_pc(cur_pc),
		.el1_context_id_register(el1_ctx), .el2_context_id(el2_ctx),
		.vmid_value(vmid_value), .fc_valid(fc_valid), .fc_ready(fc_ready),
		.fc_data(fc_data), .out_valid(out_valid), .out_ready(out_ready),
		.out_data(out_data));

	tce_sink sink (.clk(clk), .sys_rst(sys_rst), .out_valid(out_valid),
		.out_ready(out_ready), .out_data(out_data), .stall(stall));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic report_and_stop;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic timeout(input string what);
		error_cnt++;
		$display("[FAIL] %0t timeout waiting for %s", $time, what);
		report_and_stop();
	endtask

	// next logged element; the bound covers a full fifo drain
	task automatic expect_el(input logic [2:0] k, input logic [4:0] x);
		int n;
		for (n = 0; n < 100 && sink.got.size() == 0; n++) begin
			@(negedge clk);
		end
		if (sink.got.size() == 0) begin
			timeout("element");
		end
		e = sink.got.pop_front();
		check(64'(e.kind), 64'(k), "element kind");
		if (k == tce_pkg::KIND_EXCEPTION) begin
			check(64'(e.exc_type), 64'(x), "exception type");
		end
	endtask

	// anything that shows up here is surplus; flush it so later checks stay aligned
	task automatic expect_quiet;
		repeat (30) @(negedge clk);
		check(64'(sink.got.size()), 64'h0, "surplus element");
		sink.got.delete();
	endtask

	// one-cycle event pulse by bit position in the event struct
	task automatic pulse(input int b);
		@(negedge clk);
		ev[b] = 1'b1;
		@(negedge clk);
		ev[b] = 1'b0;
	endtask

	task automatic send_flow(input logic tk, input logic ind, input logic rsm,
		input logic [63:0] tgt);
		int n;
		@(negedge clk);
		fc_data = '0;
		fc_data.taken = tk;
		fc_data.indirect = ind;
		fc_data.rs_match = rsm;
		fc_data.target_active = 1'b1;
		fc_data.target = tgt;
		fc_valid = 1'b1;
		for (n = 0; n < 100 && fc_ready !== 1'b1; n++) begin
			@(negedge clk);
		end
		if (fc_ready !== 1'b1) begin
			timeout("flow slot");
		end
		@(negedge clk);
		fc_valid = 1'b0;
	endtask

	task automatic start_tx;
		ev.in_tx = 1'b1;
		ev.trace_active = 1'b1;
		pulse(13);
		expect_el(tce_pkg::KIND_TSTART, 5'h00);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic sc_gate;
		ev.in_tx = 1'b1;
		ev.trace_active = 1'b1;
		pulse(11);
		ev.in_tx = 1'b0;
		expect_quiet();
	endtask

	task automatic sc_fail_target;
		start_tx();
		cur_pc = 64'h0000_0000_0000_3000;
		pulse(11);
		expect_el(tce_pkg::KIND_EXCEPTION, tce_pkg::EXC_TX_FAIL);
		expect_el(tce_pkg::KIND_TARGET, 5'h00);
		check(e.addr, 64'h0000_0000_0000_3000, "failure target");
		ev.in_tx = 1'b0;
	endtask

	// fail, prohibited entry, disable and overflow, each with tracing off at the target
	task automatic sc_fail_causes;
		int causes[4] = '{11, 10, 9, 8};
		foreach (causes[i]) begin
			start_tx();
			ev.trace_active = 1'b0;
			pulse(causes[i]);
			ev.in_tx = 1'b0;
			expect_el(tce_pkg::KIND_EXCEPTION, tce_pkg::EXC_TX_FAIL);
			expect_quiet();
		end
	endtask

	task automatic sc_reset;
		for (int r = 0; r < 2; r++) begin
			cfg.reset_trace_required = r[0];
			start_tx();
			ev.trace_active = 1'b0;
			pulse(7);
			ev.in_tx = 1'b0;
			if (r == 1) begin
				expect_el(tce_pkg::KIND_EXCEPTION, tce_pkg::EXC_TX_FAIL);
			end
			expect_el(tce_pkg::KIND_EXCEPTION, tce_pkg::EXC_PE_RESET);
			expect_quiet();
		end
	endtask

	// starts right after a processor reset, so the first context reads zero
	task automatic sc_context;
		ev.trace_active = 1'b1;
		cur_pc = 64'h0000_0000_0000_2000;
		pulse(1);
		expect_el(tce_pkg::KIND_CONTEXT, 5'h00);
		check(64'(e.ctx_id), 64'h0, "context id after reset");
		check(64'(e.vmid), 64'h0, "vmid after reset");
		expect_el(tce_pkg::KIND_TARGET, 5'h00);
		check(e.addr, 64'h0000_0000_0000_2000, "non-periodic address");
		pulse(5);
		send_flow(1'b0, 1'b0, 1'b0, 64'h0000_0000_0000_1000);
		expect_el(tce_pkg::KIND_CONTEXT, 5'h00);
		check(64'(e.ctx_id), 64'(el1_ctx), "context id source");
		check(64'(e.vmid), 64'(vmid_value), "vmid passed");
		expect_el(tce_pkg::KIND_FLOW, 5'h00);
		pulse(0);
		expect_el(tce_pkg::KIND_CONTEXT, 5'h00);
		expect_el(tce_pkg::KIND_TARGET, 5'h00);
		check(e.addr, 64'h0000_0000_0000_1000, "periodic address");
		cfg.hyp_vmid_trace_allow = 1'b0;
		pulse(4);
		expect_el(tce_pkg::KIND_CONTEXT, 5'h00);
		check(64'(e.vmid), 64'h0, "filtered vmid");
		cfg.hyp_vmid_trace_allow = 1'b1;
		expect_quiet();
	endtask

	// indirect, return-stack match, broadcast direct, then a Q element
	task automatic sc_targets;
		send_flow(1'b1, 1'b1, 1'b0, 64'h0000_0000_0000_4000);
		send_flow(1'b1, 1'b1, 1'b1, 64'h0000_0000_0000_5000);
		cfg.branch_broadcast_control = 1'b1;
		send_flow(1'b1, 1'b0, 1'b0, 64'h0000_0000_0000_6000);
		expect_el(tce_pkg::KIND_FLOW, 5'h00);
		expect_el(tce_pkg::KIND_TARGET, 5'h00);
		check(e.addr, 64'h0000_0000_0000_4000, "indirect target");
		expect_el(tce_pkg::KIND_FLOW, 5'h00);
		expect_el(tce_pkg::KIND_FLOW, 5'h00);
		expect_el(tce_pkg::KIND_TARGET, 5'h00);
		check(e.addr, 64'h0000_0000_0000_6000, "broadcast target");
		cfg.branch_broadcast_control = 1'b0;
		cur_pc = 64'h0000_0000_0000_8000;
		pulse(2);
		expect_el(tce_pkg::KIND_TARGET, 5'h00);
		check(e.addr, 64'h0000_0000_0000_8000, "address after Q");
		expect_quiet();
	endtask

	// exception taken in the cycle of a context write: exception first, then context
	task automatic sc_exception;
		cfg.high_el_64 = 1'b0;
		@(negedge clk);
		fc_data = '0;
		fc_data.is_exception = 1'b1;
		fc_data.exc_type = 5'h05;
		fc_data.taken = 1'b1;
		fc_data.cse = 1'b1;
		fc_data.target_active = 1'b1;
		fc_data.target = 64'h0000_0000_0000_9000;
		fc_valid = 1'b1;
		ev.sysreg_ctx_write = 1'b1;
		@(negedge clk);
		fc_valid = 1'b0;
		ev.sysreg_ctx_write = 1'b0;
		expect_el(tce_pkg::KIND_EXCEPTION, 5'h05);
		expect_el(tce_pkg::KIND_CONTEXT, 5'h00);
		check(64'(e.ctx_id), 64'(el2_ctx), "context id, 32-bit top level");
		expect_el(tce_pkg::KIND_TARGET, 5'h00);
		check(e.addr, 64'h0000_0000_0000_9000, "exception target");
		cfg.high_el_64 = 1'b1;
		expect_quiet();
	endtask

	// fill the 8-word fifo plus the held slot with the sink stalled
	task automatic sc_fifo;
		stall = 1'b1;
		repeat (9) send_flow(1'b0, 1'b0, 1'b0, 64'h0000_0000_0000_7000);
		repeat (5) @(negedge clk);
		check(64'(fc_ready), 64'h0, "flow slot held while full");
		check(64'(out_valid), 64'h1, "head waiting");
		stall = 1'b0;
		repeat (9) expect_el(tce_pkg::KIND_FLOW, 5'h00);
		expect_quiet();
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		ev = '0;
		cfg = '0;
		cfg.vctx_trace_en = 1'b1;
		cfg.hyp_vmid_trace_allow = 1'b1;
		cfg.high_el_64 = 1'b1;
		cur_pc = '0;
		el1_ctx = 32'h0000_00A5;
		el2_ctx = 32'h0000_005A;
		vmid_value = 32'h0000_0033;
		fc_valid = 1'b0;
		fc_data = '0;
		stall = 1'b0;
		error_cnt = 0;
		samples_checked = 0;
		repeat (10) @(negedge clk);
		check(64'(out_valid), 64'h0, "out_valid in reset");
		check(64'(fc_ready), 64'h0, "fc_ready in reset");
		sys_rst = 1'b0;
		sc_gate();
		sc_fail_target();
		sc_fail_causes();
		sc_reset();
		sc_context();
		sc_targets();
		sc_exception();
		sc_fifo();
		report_and_stop();
	end
endmodule
